// file: hdl/rtc_alarm_cmp.sv
//==========================================================================
// Purpose: Alarm comparison once per second tick
// Assumes: Time fields are BCD as held by the time counters
// Notes:   hit is a one-cycle pulse, one clock after the tick
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_alarm_cmp (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	rtc_alarm_if.cmp al
);
	import rtc_pkg::*;

	rtc_alm_state_t st_reg;
	rtc_alm_state_t st_next;

	// Mask code to match; unlisted codes fall back to every second
	function automatic logic alarm_match(input logic [3:0] m,
		input logic s, input logic mi, input logic h, input logic d);
		case (m)
			4'b1110: alarm_match = s;
			4'b1100: alarm_match = s & mi;
			4'b1000: alarm_match = s & mi & h;
			4'b0000: alarm_match = s & mi & h & d;
			default: alarm_match = 1'b1;
		endcase
	endfunction

	logic [3:0] mask;
	logic eq_s;
	logic eq_m;
	logic eq_h;
	logic eq_d;
	logic [7:0] dd_ref;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			mask[i] = al.alarm[i][`RTC_B_AMASK];
		end
		dd_ref = al.alarm[`RTC_I_DD][`RTC_B_DYDT] ? al.day : al.date;
		eq_s = ((al.alarm[`RTC_I_SEC] ^ al.sec) & `RTC_M_SECMIN) == '0;
		eq_m = ((al.alarm[`RTC_I_MIN] ^ al.min) & `RTC_M_SECMIN) == '0;
		eq_h = ((al.alarm[`RTC_I_HR] ^ al.hour) & `RTC_M_HR6) == '0;
		eq_d = ((al.alarm[`RTC_I_DD] ^ dd_ref) & `RTC_M_HR6) == '0;
		st_next = st_reg;
		// Checked only on the tick, and only while transfers run
		st_next.hit = al.tick & al.te
			& alarm_match(mask, eq_s, eq_m, eq_h, eq_d);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign al.hit = st_reg.hit;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	AST_ALM_EVERY_SEC: assert property (
		al.tick && al.te && mask == 4'b0110 |=> al.hit)
		else $error("bad mask code did not fire every second");
	AST_ALM_NEEDS_TE: assert property (
		!al.te |=> !al.hit)
		else $error("alarm hit with transfers off");
	AST_ALM_TICK_ONLY: assert property (
		al.hit |-> $past(al.tick))
		else $error("alarm hit without a tick");
endmodule

// file: hdl/rtc_alarm_if.sv
//==========================================================================
// Purpose: Carries alarm settings and current time to the comparator
// Assumes: Single clock domain
// Notes:   ctl side drives settings, cmp side returns the hit pulse
`timescale 1ns/1ps

interface rtc_alarm_if;
	logic tick;
	logic te;
	logic [3:0][7:0] alarm;
	logic [7:0] sec;
	logic [7:0] min;
	logic [7:0] hour;
	logic [7:0] day;
	logic [7:0] date;
	logic hit;

	modport ctl (output tick, te, alarm, sec, min, hour, day, date,
		input hit);
	modport cmp (input tick, te, alarm, sec, min, hour, day, date,
		output hit);
endinterface

// file: hdl/rtc_ctrl_regs.sv
//==========================================================================
// Purpose: Control and status registers of a battery-backed RTC
// Assumes: Parallel bus pins already synchronous to i_clk
// Notes:   Read data follows the address by one clock
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_ctrl_regs #(
	parameter int unsigned RST_PULSE_CYC =
		`RTC_RST_MIN_MS * 1000 * `RTC_CLK_MHZ
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [`RTC_AW-1:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	input wire logic i_sec_tick,
	input wire logic [7:0] i_time_sec,
	input wire logic [7:0] i_time_min,
	input wire logic [7:0] i_time_hour,
	input wire logic [7:0] i_time_day,
	input wire logic [7:0] i_time_date,
	input wire logic i_kick_event,
	input wire logic i_dog_timeout,
	input wire logic i_power_fail,
	input wire logic i_on_backup,
	input wire logic i_aux_battery_supply,
	input wire logic i_main_battery_low,
	input wire logic i_aux_battery_low,
	input wire logic i_osc_32k,
	input wire logic [7:0] i_ram_rdata,
	output logic o_osc_run,
	output logic o_xtal_sel,
	output logic o_update_enable,
	output logic o_square_wave_out,
	output logic o_irq_n,
	output logic o_power_request_n,
	output logic o_power_request_n_oe,
	output logic o_rst_n,
	output logic [15:0] o_dog_period,
	output logic o_dog_reload,
	output logic [7:0] o_ram_addr,
	output logic [7:0] o_ram_wdata,
	output logic o_ram_wr
);
	import rtc_pkg::*;

	if (RST_PULSE_CYC <
		`RTC_RST_MIN_MS * 1000 * `RTC_CLK_MHZ / 1000) begin : g_chk
		$error("RST_PULSE_CYC too small");
	end

	rtc_state_t st_reg;
	rtc_state_t st_next;

	logic rd_act;
	logic wr_act;
	logic wr_take;
	logic acc_end;
	logic interrupt_pending_flag;
	logic rst_active;
	logic rst_start;
	logic [7:0] ctla;
	logic [7:0] ctlb;
	logic [7:0] month_rd;

	rtc_alarm_if al ();

	//======================================================================
	// Submodules
	rtc_alarm_cmp u_alarm (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.al(al.cmp)
	);

	rtc_rst_pulse #(
		.PULSE_CYC(RST_PULSE_CYC)
	) u_rst (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_start(rst_start),
		.o_active(rst_active)
	);

	assign al.tick = i_sec_tick;
	assign al.te = st_reg.te;
	assign al.alarm = st_reg.alarm;
	assign al.sec = i_time_sec;
	assign al.min = i_time_min;
	assign al.hour = i_time_hour;
	assign al.day = i_time_day;
	assign al.date = i_time_date;

	//======================================================================
	// Bus decode
	assign rd_act = !i_ce_n && !i_oe_n && i_we_n;
	assign wr_act = !i_ce_n && !i_we_n;
	assign wr_take = wr_act && !st_reg.we_prev;
	// Access ends on a strobe release or an address change
	assign acc_end = !rd_act || i_addr != st_reg.acc_addr;

	assign interrupt_pending_flag = (st_reg.alarm_flag && st_reg.alarm_int_enable)
		|| (st_reg.kick_flag && st_reg.kick_int_enable)
		|| (st_reg.dog_timeout_flag && st_reg.dog_enable);
	// Single-shot only when armed and steered to reset
	assign rst_start = i_dog_timeout && st_reg.dog_enable && st_reg.dog_steer
		&& !rst_active;

	always_comb begin
		ctla = '0;
		ctla[`RTC_B_MAIN_BATTERY_LOW] = i_main_battery_low;
		ctla[`RTC_B_AUX_BATTERY_LOW] = i_aux_battery_low;
		ctla[`RTC_B_PRS] = st_reg.power_fail_hold;
		ctla[`RTC_B_PAB] = st_reg.power_release;
		ctla[`RTC_B_TDF] = st_reg.alarm_flag;
		ctla[`RTC_B_KSF] = st_reg.kick_flag;
		ctla[`RTC_B_WDF] = st_reg.dog_timeout_flag;
		ctla[`RTC_B_INTERRUPT_PENDING_FLAG] = interrupt_pending_flag;
		ctlb = {st_reg.te, st_reg.cs, st_reg.ram_autoincrement_enable, st_reg.alarm_wake_enable,
			st_reg.alarm_int_enable, st_reg.kick_int_enable, st_reg.dog_enable, st_reg.dog_steer};
		month_rd = {st_reg.oscillator_disable, st_reg.clock_output_enable_n_n, st_reg.backup_clock_output_enable,
			st_reg.month};
	end

	//======================================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.we_prev = wr_act;
		st_next.dog_reload = 1'b0;
		st_next.ram_wr = 1'b0;

		case (i_addr)
			`RTC_A_SEC: st_next.rd_data = i_time_sec;
			`RTC_A_MIN: st_next.rd_data = i_time_min;
			`RTC_A_HR: st_next.rd_data = i_time_hour;
			`RTC_A_DAY: st_next.rd_data = i_time_day;
			`RTC_A_DATE: st_next.rd_data = i_time_date;
			`RTC_A_MON: st_next.rd_data = month_rd;
			`RTC_A_ALM_SEC: st_next.rd_data = st_reg.alarm[`RTC_I_SEC];
			`RTC_A_ALM_MIN: st_next.rd_data = st_reg.alarm[`RTC_I_MIN];
			`RTC_A_ALM_HR: st_next.rd_data = st_reg.alarm[`RTC_I_HR];
			`RTC_A_ALM_DD: st_next.rd_data = st_reg.alarm[`RTC_I_DD];
			`RTC_A_DOG_LO: st_next.rd_data = st_reg.dog[0];
			`RTC_A_DOG_HI: st_next.rd_data = st_reg.dog[1];
			`RTC_A_CTLA: st_next.rd_data = ctla;
			`RTC_A_CTLB: st_next.rd_data = ctlb;
			`RTC_A_RAM_A: st_next.rd_data = st_reg.ram_addr;
			`RTC_A_RAM_D: st_next.rd_data = i_ram_rdata;
			default: st_next.rd_data = `RTC_ZERO8;
		endcase

		// Register writes
		if (wr_take) begin
			case (i_addr)
				`RTC_A_MON: begin
					st_next.oscillator_disable = i_data[`RTC_B_OSCILLATOR_DISABLE];
					st_next.clock_output_enable_n_n = i_data[`RTC_B_CLOCK_OUTPUT_ENABLE_N];
					st_next.backup_clock_output_enable = i_data[`RTC_B_BACKUP_CLOCK_OUTPUT_ENABLE];
					st_next.month = i_data[`RTC_MON_W-1:0];
				end
				`RTC_A_ALM_SEC: st_next.alarm[`RTC_I_SEC] = i_data;
				`RTC_A_ALM_MIN: st_next.alarm[`RTC_I_MIN] = i_data;
				`RTC_A_ALM_HR: st_next.alarm[`RTC_I_HR] = i_data;
				`RTC_A_ALM_DD: st_next.alarm[`RTC_I_DD] = i_data;
				`RTC_A_DOG_LO: begin
					st_next.dog[0] = i_data;
					st_next.dog_reload = 1'b1;
				end
				`RTC_A_DOG_HI: begin
					st_next.dog[1] = i_data;
					st_next.dog_reload = 1'b1;
				end
				`RTC_A_CTLA: begin
					st_next.power_fail_hold = i_data[`RTC_B_PRS];
					st_next.power_release = i_data[`RTC_B_PAB];
					if (!i_data[`RTC_B_TDF]) begin
						st_next.alarm_flag = 1'b0;
					end
					st_next.kick_flag = i_data[`RTC_B_KSF];
					if (!i_data[`RTC_B_WDF]) begin
						st_next.dog_timeout_flag = 1'b0;
					end
				end
				`RTC_A_CTLB: begin
					st_next.te = i_data[`RTC_B_TE];
					st_next.cs = i_data[`RTC_B_CS];
					st_next.ram_autoincrement_enable = i_data[`RTC_B_BME];
					st_next.alarm_wake_enable = i_data[`RTC_B_TPE];
					st_next.alarm_int_enable = i_data[`RTC_B_TIE];
					st_next.kick_int_enable = i_data[`RTC_B_KIE];
					st_next.dog_enable = i_data[`RTC_B_WDE];
					st_next.dog_steer = i_data[`RTC_B_WDS];
				end
				`RTC_A_RAM_A: st_next.ram_addr = i_data;
				`RTC_A_RAM_D: begin
					st_next.ram_wr = 1'b1;
					st_next.ram_wdata = i_data;
				end
				default: begin
				end
			endcase
		end

		// Read access tracker; the clearing happens when the access ends
		case (st_reg.acc)
			RTC_ACC_IDLE: begin
				if (rd_act && i_addr == `RTC_A_CTLA) begin
					st_next.acc = RTC_ACC_RD_FLAGS;
				end else if (rd_act && i_addr == `RTC_A_RAM_D) begin
					st_next.acc = RTC_ACC_RD_RAM;
				end
				st_next.acc_addr = i_addr;
			end
			RTC_ACC_RD_FLAGS: begin
				if (acc_end) begin
					st_next.acc = RTC_ACC_IDLE;
					st_next.alarm_flag = 1'b0;
					st_next.kick_flag = 1'b0;
					st_next.dog_timeout_flag = 1'b0;
				end
			end
			RTC_ACC_RD_RAM: begin
				if (acc_end) begin
					st_next.acc = RTC_ACC_IDLE;
					if (st_reg.ram_autoincrement_enable) begin
						st_next.ram_addr = st_reg.ram_addr + `RTC_ONE8;
					end
				end
			end
			default: st_next.acc = RTC_ACC_IDLE;
		endcase

		// Address moves after the write has gone out on the old one
		if (st_reg.ram_wr && st_reg.ram_autoincrement_enable) begin
			st_next.ram_addr = st_reg.ram_addr + `RTC_ONE8;
		end

		// Hardware sets win over any clear in the same cycle
		if (al.hit) begin
			st_next.alarm_flag = 1'b1;
		end
		if (i_kick_event) begin
			st_next.kick_flag = 1'b1;
		end
		if (i_dog_timeout) begin
			st_next.dog_timeout_flag = 1'b1;
		end
		if (rst_start) begin
			st_next.dog_enable = 1'b0;
		end
		if ((st_reg.alarm_flag && st_reg.alarm_wake_enable) || st_reg.kick_flag) begin
			st_next.power_release = 1'b0;
		end

		st_next.square_wave_out = 1'b0;
		if (!st_reg.oscillator_disable) begin
			if (!i_on_backup && !st_reg.clock_output_enable_n_n) begin
				st_next.square_wave_out = i_osc_32k;
			end else if (i_on_backup && st_reg.backup_clock_output_enable
				&& i_aux_battery_supply) begin
				st_next.square_wave_out = i_osc_32k;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	//======================================================================
	// Outputs
	assign o_data = st_reg.rd_data;
	assign o_data_oe = rd_act;
	assign o_osc_run = !st_reg.oscillator_disable;
	assign o_xtal_sel = st_reg.cs;
	assign o_update_enable = st_reg.te;
	assign o_square_wave_out = st_reg.square_wave_out;
	assign o_irq_n = !interrupt_pending_flag;
	assign o_power_request_n = 1'b0;
	// Open drain: released by the bit, or by power fail without hold
	assign o_power_request_n_oe = !st_reg.power_release
		&& (!i_power_fail || st_reg.power_fail_hold);
	assign o_rst_n = !rst_active;
	assign o_dog_period = {st_reg.dog[1], st_reg.dog[0]};
	assign o_dog_reload = st_reg.dog_reload;
	assign o_ram_addr = st_reg.ram_addr;
	assign o_ram_wdata = st_reg.ram_wdata;
	assign o_ram_wr = st_reg.ram_wr;

	//======================================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_flag_read_end;
		st_reg.acc == RTC_ACC_RD_FLAGS && acc_end && !al.hit
			&& !i_kick_event && !i_dog_timeout;
	endsequence

	AST_RD_CLEARS_FLAGS: assert property (
		s_flag_read_end |=> !st_reg.alarm_flag && !st_reg.kick_flag && !st_reg.dog_timeout_flag
			&& o_irq_n)
		else $error("flag read did not clear flags");
	AST_PAB_HW_CLEAR: assert property (
		(st_reg.alarm_flag && st_reg.alarm_wake_enable) || st_reg.kick_flag |=> !st_reg.power_release)
		else $error("release bit not cleared by flags");
	AST_ALARM_SETS: assert property (
		al.hit |=> st_reg.alarm_flag)
		else $error("alarm hit lost");
	AST_KICK_SETS: assert property (
		i_kick_event |=> st_reg.kick_flag)
		else $error("kick event lost");
	AST_DOG_SETS: assert property (
		i_dog_timeout |=> st_reg.dog_timeout_flag)
		else $error("watchdog timeout lost");
	AST_IRQ_ALARM: assert property (
		st_reg.alarm_flag && st_reg.alarm_int_enable |-> !o_irq_n)
		else $error("enabled alarm flag without interrupt");
	AST_PWR_FAIL_REL: assert property (
		i_power_fail && !st_reg.power_fail_hold |-> !o_power_request_n_oe)
		else $error("power request held in power fail");
	AST_TE_SW_ONLY: assert property (
		!(wr_take && i_addr == `RTC_A_CTLB) |=> st_reg.te == $past(st_reg.te))
		else $error("transfer enable changed without a write");
	AST_WDE_DROPS: assert property (
		$fell(o_rst_n) |-> !st_reg.dog_enable ##1 !o_rst_n)
		else $error("watchdog enable not cleared at reset pulse");
endmodule

// file: hdl/rtc_defs.svh
//==========================================================================
// Purpose: Addresses, bit positions and timing figures of the RTC controls
// Assumes: Included by the package and by every design module
// Notes:   Definitions only
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

//==========================================================================
// Register addresses
`define RTC_AW 5
`define RTC_A_SEC 5'h00
`define RTC_A_MIN 5'h01
`define RTC_A_HR 5'h02
`define RTC_A_DAY 5'h03
`define RTC_A_DATE 5'h04
`define RTC_A_MON 5'h05
`define RTC_A_ALM_SEC 5'h08
`define RTC_A_ALM_MIN 5'h09
`define RTC_A_ALM_HR 5'h0A
`define RTC_A_ALM_DD 5'h0B
`define RTC_A_DOG_LO 5'h0C
`define RTC_A_DOG_HI 5'h0D
`define RTC_A_CTLA 5'h0E
`define RTC_A_CTLB 5'h0F
`define RTC_A_RAM_A 5'h10
`define RTC_A_RAM_D 5'h13

//==========================================================================
// Bit positions
`define RTC_B_OSCILLATOR_DISABLE 7
`define RTC_B_CLOCK_OUTPUT_ENABLE_N 6
`define RTC_B_BACKUP_CLOCK_OUTPUT_ENABLE 5
`define RTC_MON_W 5
`define RTC_B_AMASK 7
`define RTC_B_DYDT 6
`define RTC_B_MAIN_BATTERY_LOW 7
`define RTC_B_AUX_BATTERY_LOW 6
`define RTC_B_PRS 5
`define RTC_B_PAB 4
`define RTC_B_TDF 3
`define RTC_B_KSF 2
`define RTC_B_WDF 1
`define RTC_B_INTERRUPT_PENDING_FLAG 0
`define RTC_B_TE 7
`define RTC_B_CS 6
`define RTC_B_BME 5
`define RTC_B_TPE 4
`define RTC_B_TIE 3
`define RTC_B_KIE 2
`define RTC_B_WDE 1
`define RTC_B_WDS 0

//==========================================================================
// Field masks and indices
`define RTC_M_SECMIN 8'h7F
`define RTC_M_HR6 8'h3F
`define RTC_I_SEC 0
`define RTC_I_MIN 1
`define RTC_I_HR 2
`define RTC_I_DD 3
`define RTC_ONE8 8'h01
`define RTC_ZERO8 8'h00

//==========================================================================
// Timing
`define RTC_CLK_MHZ 250
`define RTC_RST_MIN_MS 40
`define RTC_RST_MAX_MS 200
`define RTC_PULSE_CW 26

`endif

// file: hdl/rtc_pkg.sv
//==========================================================================
// Purpose: Types shared by the RTC control modules
// Assumes: rtc_defs.svh supplies widths
// Notes:   Each module keeps its whole state in one struct from here
`include "rtc_defs.svh"

package rtc_pkg;

	typedef enum logic [1:0] {
		RTC_ACC_IDLE = 2'b00,
		RTC_ACC_RD_FLAGS = 2'b01,
		RTC_ACC_RD_RAM = 2'b10
	} rtc_acc_t;

	typedef struct packed {
		logic oscillator_disable;
		logic clock_output_enable_n_n;
		logic backup_clock_output_enable;
		logic [`RTC_MON_W-1:0] month;
		logic [3:0][7:0] alarm;
		logic [1:0][7:0] dog;
		logic power_fail_hold;
		logic power_release;
		logic alarm_flag;
		logic kick_flag;
		logic dog_timeout_flag;
		logic te;
		logic cs;
		logic ram_autoincrement_enable;
		logic alarm_wake_enable;
		logic alarm_int_enable;
		logic kick_int_enable;
		logic dog_enable;
		logic dog_steer;
		logic [7:0] ram_addr;
		rtc_acc_t acc;
		logic [`RTC_AW-1:0] acc_addr;
		logic we_prev;
		logic [7:0] rd_data;
		logic square_wave_out;
		logic dog_reload;
		logic ram_wr;
		logic [7:0] ram_wdata;
	} rtc_state_t;

	typedef struct packed {
		logic hit;
	} rtc_alm_state_t;

	typedef struct packed {
		logic busy;
		logic [`RTC_PULSE_CW-1:0] cnt;
	} rtc_pulse_state_t;

endpackage

// file: hdl/rtc_rst_pulse.sv
//==========================================================================
// Purpose: Timed active period of the watchdog reset output
// Assumes: i_start is a one-cycle pulse
// Notes:   Starts while busy are ignored
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_rst_pulse #(
	parameter int unsigned PULSE_CYC = 10_000_000
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_start,
	output logic o_active
);
	import rtc_pkg::*;

	if (PULSE_CYC < 1 || PULSE_CYC >= (1 << `RTC_PULSE_CW)) begin : g_chk
		$error("PULSE_CYC out of range");
	end

	localparam logic [`RTC_PULSE_CW-1:0] LAST =
		`RTC_PULSE_CW'(PULSE_CYC - 1);

	rtc_pulse_state_t st_reg;
	rtc_pulse_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (st_reg.busy) begin
			if (st_reg.cnt == LAST) begin
				st_next.busy = 1'b0;
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
		end else if (i_start) begin
			st_next.busy = 1'b1;
			st_next.cnt = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_active = st_reg.busy;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	AST_PULSE_HOLDS: assert property (
		st_reg.busy && st_reg.cnt != LAST |=> st_reg.busy)
		else $error("reset pulse ended early");
	AST_PULSE_ENDS: assert property (
		st_reg.busy && st_reg.cnt == LAST |=> !st_reg.busy)
		else $error("reset pulse overran");
endmodule

// file: tb/rtc_control_status_regs_tb.sv
//====
// Purpose: Self-checking bench of the RTC control registers
// Assumes: rtc_host drives the bus; time counters are bench inputs
// Notes:   Watchdog reset pulse shortened to 10000 clocks
`timescale 1ns/1ps

module rtc_control_status_regs_tb;
	localparam int unsigned PUL = 10000;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic ce_n, oe_n, we_n, o_sqw, o_irq_n, o_pr_n, o_pr_oe, o_rst_n;
	logic o_xs, o_ue, o_run, ah;
	logic [4:0] addr;
	logic [7:0] wdat, rdat, d, v, o_ra, o_rw;
	logic tick = 0, kick = 0, dto = 0, pfail = 0, blo1 = 1, blo2 = 0;
	logic osc = 0;
	logic [7:0] tm [5] = '{8'h30, 8'h15, 8'h08, 8'h05, 8'h05};
	logic [7:0] ab [4] = '{8'h30, 8'h15, 8'h08, 8'h05};
	logic [3:0] codes [6] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0, 4'h6};
	logic [31:0] rs = 32'h0d06_b168;
	int error_cnt = 0, total_checks = 0, cyc = 0, n, fi;

	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) osc <= #1 ~osc;

	rtc_host u_host (.i_clk(i_clk), .i_rdata(rdat), .o_ce_n(ce_n),
		.o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_data(wdat));

	rtc_ctrl_regs #(.RST_PULSE_CYC(PUL)) u_dut (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_addr(addr), .i_data(wdat), .o_data(rdat),
		.o_data_oe(), .i_sec_tick(tick), .i_time_sec(tm[0]),
		.i_time_min(tm[1]), .i_time_hour(tm[2]), .i_time_day(tm[3]),
		.i_time_date(tm[4]), .i_kick_event(kick), .i_dog_timeout(dto),
		.i_power_fail(pfail), .i_on_backup(1'b0),
		.i_aux_battery_supply(1'b1), .i_main_battery_low(blo1),
		.i_aux_battery_low(blo2), .i_osc_32k(osc),
		.i_ram_rdata(8'h00), .o_osc_run(o_run), .o_xtal_sel(o_xs),
		.o_update_enable(o_ue), .o_square_wave_out(o_sqw),
		.o_irq_n(o_irq_n), .o_power_request_n(o_pr_n),
		.o_power_request_n_oe(o_pr_oe), .o_rst_n(o_rst_n),
		.o_dog_period(), .o_dog_reload(), .o_ram_addr(o_ra),
		.o_ram_wdata(o_rw), .o_ram_wr());

	//====
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chb(input logic got, input logic exp);
		chk({7'h0, got}, {7'h0, exp});
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		@(posedge i_clk) #1;
		s = 1'b1;
		wt(1);
		s = 1'b0;
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Unlisted mask codes fire every second; f==4 perturbs the unused field
	function automatic logic ahit(input logic [3:0] c, input int f);
		return (c != 4'hF && c != 4'hE && c != 4'hC && c != 4'h8 &&
			c != 4'h0) || f == 4 || c[f[1:0]];
	endfunction

	// Hang guard sized well above the watchdog pulse and alarm sweep
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			summarize();
		end
	end

	//====
	// Main sequence
	initial begin
		wt(20);
		i_sys_rst = 1'b0;
		chb(o_run, 1'b1);
		chb(o_irq_n, 1'b1);
		chb(o_rst_n, 1'b1);
		chb(o_pr_n, 1'b0);
		u_host.rd(5'h05, d);
		chk(d, 8'h00);
		u_host.rd(5'h0F, d);
		chk(d, 8'h00);
		u_host.rd(5'h0E, d);
		chk(d, 8'h80);
		{blo1, blo2} = 2'b01;
		u_host.rd(5'h0E, d);
		chk(d, 8'h40);
		blo2 = 1'b0;
		for (int i = 0; i < 16; i++) begin
			rs = lfsr(rs);
			v = rs[7:0];
			u_host.wr(i[0] ? 5'h05 : 5'h0F, v);
			u_host.rd(i[0] ? 5'h05 : 5'h0F, d);
			chk(d, v);
			if (i[0]) begin
				#1;
				chb(o_run, ~v[7]);
				chb(o_sqw, ~v[7] & ~v[6] & ~osc);
			end else begin
				chb(o_xs, v[6]);
				chb(o_ue, v[7]);
			end
		end
		u_host.wr(5'h14, 8'hA5);
		u_host.rd(5'h14, d);
		chk(d, 8'h00);
		// Kick flag, interrupt and read-to-clear
		u_host.wr(5'h0F, 8'h84);
		pulse(kick);
		wt(1);
		chb(o_irq_n, 1'b0);
		u_host.rd(5'h0E, d);
		chk(d, 8'h05);
		wt(2);
		chb(o_irq_n, 1'b1);
		u_host.wr(5'h0E, 8'h04);
		chb(o_irq_n, 1'b0);
		// A set kick flag would clear the release bit in the same write
		u_host.wr(5'h0E, 8'h00);
		chb(o_irq_n, 1'b1);
		u_host.wr(5'h0E, 8'h10);
		chb(o_irq_n, 1'b1);
		chb(o_pr_oe, 1'b0);
		pulse(kick);
		wt(1);
		chb(o_pr_oe, 1'b1);
		u_host.wr(5'h0E, 8'h20);
		pfail = 1'b1;
		wt(1);
		chb(o_pr_oe, 1'b1);
		u_host.wr(5'h0E, 8'h00);
		chb(o_pr_oe, 1'b0);
		pfail = 1'b0;
		// Alarm mask sweep, one field off at a time
		u_host.wr(5'h0F, 8'h88);
		for (int i = 0; i < 6; i++) begin
			for (int dy = 0; dy < 2; dy++) begin
				for (int f = 0; f < 5; f++) begin
					for (int k = 0; k < 4; k++) begin
						u_host.wr(5'h08 + 5'(k), {codes[i][k], ab[k][6:0]} |
							((k == 3 && dy == 1) ? 8'h40 : 8'h00));
					end
					fi = f < 3 ? f : ((f == 3) == (dy == 1) ? 3 : 4);
					tm[fi] = tm[fi] + 8'h01;
					ah = ahit(codes[i], f);
					pulse(tick);
					wt(2);
					chb(o_irq_n, ~ah);
					u_host.rd(5'h0E, d);
					chb(d[3], ah);
					tm[fi] = tm[fi] - 8'h01;
				end
			end
		end
		u_host.wr(5'h0F, 8'h90);
		u_host.wr(5'h0E, 8'h10);
		pulse(tick);
		wt(3);
		chb(o_pr_oe, 1'b1);
		u_host.rd(5'h0E, d);
		u_host.wr(5'h0F, 8'h08);
		pulse(tick);
		wt(3);
		chb(o_irq_n, 1'b1);
		// Watchdog single-shot reset, then one timeout steered to interrupt
		u_host.wr(5'h0F, 8'h03);
		pulse(dto);
		wt(1);
		chb(o_rst_n, 1'b0);
		n = 0;
		while (o_rst_n !== 1'b1 && n < 3 * PUL) begin
			wt(1);
			n++;
		end
		chb(n > PUL - 8 && n < PUL + 8, 1'b1);
		u_host.rd(5'h0F, d);
		chk(d, 8'h01);
		u_host.rd(5'h0E, d);
		chk(d, 8'h02);
		u_host.rd(5'h0E, d);
		chk(d, 8'h00);
		u_host.wr(5'h0F, 8'h02);
		pulse(dto);
		wt(1);
		chb(o_irq_n, 1'b0);
		u_host.wr(5'h0E, 8'h00);
		chb(o_irq_n, 1'b1);
		// RAM address auto-increment
		u_host.wr(5'h0F, 8'h20);
		u_host.wr(5'h10, 8'h40);
		u_host.wr(5'h13, 8'h5A);
		wt(1);
		chk(o_ra, 8'h41);
		chk(o_rw, 8'h5A);
		u_host.wr(5'h0F, 8'h00);
		u_host.wr(5'h13, 8'hC3);
		wt(1);
		chk(o_ra, 8'h41);
		summarize();
	end
endmodule

// file: tb/rtc_host.sv
//====
// Purpose: Host processor model on the byte-wide register bus
// Assumes: Strobes change 1 ns after a rising clock edge
// Notes:   Released data lines carry the inverse of the last byte
`timescale 1ns/1ps

module rtc_host (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [4:0] o_addr,
	output logic [7:0] o_data
);
	initial begin
		{o_ce_n, o_oe_n, o_we_n, o_addr, o_data} = {3'b111, 13'h0};
	end

	// Strobes held for one edge, then a full idle clock before the next
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk) #1;
		{o_ce_n, o_we_n, o_addr, o_data} = {2'b00, a, d};
		@(posedge i_clk) #1;
		{o_ce_n, o_we_n, o_data} = {2'b11, ~d};
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge i_clk) #1;
		{o_ce_n, o_oe_n, o_addr} = {2'b00, a};
		repeat (2) @(posedge i_clk);
		d = i_rdata;
		#1;
		{o_ce_n, o_oe_n} = 2'b11;
	endtask
endmodule
